// ===== pattern_readout_defs.svh
// Constants for the pattern-register readout formatter.
`ifndef PATTERN_READOUT_DEFS_SVH
`define PATTERN_READOUT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_CTRL        4'h0
`define ADDR_LOC0        4'h1
`define ADDR_LOC1        4'h2
`define ADDR_LOC2        4'h3
`define ADDR_LOC3        4'h4
`define ADDR_STATUS      4'h5

// ----------------------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT  0
`define CTRL_FMT_LO      1
`define CTRL_FMT_HI      2
`define CTRL_DBI_BIT     3
`define CTRL_PRE_BIT     4
`define CTRL_RESET       8'h00
`define LOC_RESET        8'h00

// ----------------------------------------------------------------------------
// Format codes and timing
// ----------------------------------------------------------------------------
`define FMT_SERIAL       2'h0
`define FMT_PARALLEL     2'h1
`define FMT_STAGGER      2'h2
`define BURST_UI         8
`define READ_LATENCY     4'h4

`endif

// ===== pattern_readout_pkg.sv
// Types shared by the pattern-register readout formatter.
package pattern_readout_pkg;
  typedef struct packed {
    logic       valid;
    logic [1:0] loc;
    logic       array_sel;
  } read_cmd_t;

  typedef struct packed {
    logic [15:0] dq;
    logic        dq_oe;
    logic        dqs;
    logic        dqs_oe;
  } dq_out_t;
endpackage

// ===== pattern_readout.sv
// Pattern-register readout formatter: serial, parallel and staggered DQ output.
//
// Implementation choices: the plain strobed port and the address map.
`include "pattern_readout_defs.svh"

// Summary of operation
// - Four 8-bit locations readable in serial and staggered formats
// - Strobe driven with data, preamble honoured
// - Serial: UI0..UI7 repeated on every lane
// - Parallel: lane bit held whole burst
// - Parallel data comes from location 0
// - x4 parallel outputs first four bits
// - x16 parallel repeats pattern both bytes
// - x4 staggered: lane k gets (n+k) mod 4
// - x8 staggered: upper nibble copies lower
// - x16 staggered: upper byte copies lower
// - Back-to-back reads stream without gaps
// - Format code 00/01/10, 11 reserved
// - Bank bits select pattern location
// - Read inversion ignored in pattern mode
module pattern_readout #(
  parameter int          WIDTH        = 8,
  parameter logic [3:0]  READ_LATENCY = `READ_LATENCY
) (
  // System clock, register port
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [3:0]                     reg_addr,
  input  wire logic [7:0]                     reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic      [7:0]                     reg_rdata,
  // Link clock domain: command in, DQ out
  input  wire logic                           link_clk,
  input  wire logic                           link_rst,
  input  wire pattern_readout_pkg::read_cmd_t read_cmd,
  input  wire logic [15:0]                    array_data,
  output pattern_readout_pkg::dq_out_t        dq_out
);
  import pattern_readout_pkg::*;

  // --------------------------------------------------------------------------
  // Register file (system clock)
  // --------------------------------------------------------------------------
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] loc [4];
  logic [7:0] next_loc [4];
  logic [7:0] next_rdata;
  logic [1:0] busy_sync;
  logic [7:0] status;
  logic       cfg_flag, next_cfg_flag;

  always_comb begin
    next_ctrl = ctrl;
    for (int i = 0; i < 4; i++) begin
      next_loc[i] = loc[i];
    end
    next_rdata = 8'h00;
    next_cfg_flag = cfg_flag;
    // Every write flips the flag; the link side copies the settings only
    // after it has seen the flip through its synchroniser, so the copied
    // word has been stable for at least one link cycle.
    if (reg_write) begin
      next_cfg_flag = ~cfg_flag;
      case (reg_addr)
        `ADDR_CTRL: next_ctrl = reg_wdata;
        `ADDR_LOC0: next_loc[0] = reg_wdata;
        `ADDR_LOC1: next_loc[1] = reg_wdata;
        `ADDR_LOC2: next_loc[2] = reg_wdata;
        `ADDR_LOC3: next_loc[3] = reg_wdata;
        default:    next_ctrl = ctrl;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        `ADDR_CTRL:   next_rdata = ctrl;
        `ADDR_LOC0:   next_rdata = loc[0];
        `ADDR_LOC1:   next_rdata = loc[1];
        `ADDR_LOC2:   next_rdata = loc[2];
        `ADDR_LOC3:   next_rdata = loc[3];
        `ADDR_STATUS: next_rdata = status;
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl      <= `CTRL_RESET;
      reg_rdata <= 8'h00;
      cfg_flag  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        loc[i] <= `LOC_RESET;
      end
    end else begin
      ctrl      <= next_ctrl;
      reg_rdata <= next_rdata;
      cfg_flag  <= next_cfg_flag;
      for (int i = 0; i < 4; i++) begin
        loc[i] <= next_loc[i];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Crossing into the link domain
  // --------------------------------------------------------------------------
  // The 40-bit settings word is never synchronised bit by bit, since its
  // bits could land in different link cycles. Only the write flag crosses
  // through two flip-flops; the word is copied once the flip has been seen.
  // Software must still leave a few link cycles between a write and a read.
  logic [39:0] cfg_sync, next_cfg_sync;
  logic [2:0]  flag_sync;
  logic        link_busy;

  always_comb begin
    next_cfg_sync = cfg_sync;
    if (flag_sync[2] != flag_sync[1]) begin
      next_cfg_sync = {ctrl, loc[3], loc[2], loc[1], loc[0]};
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      flag_sync <= 3'h0;
      cfg_sync  <= '0;
    end else begin
      flag_sync <= {flag_sync[1:0], cfg_flag};
      cfg_sync  <= next_cfg_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_sync <= 2'h0;
    end else begin
      busy_sync <= {busy_sync[0], link_busy};
    end
  end
  assign status = {7'h00, busy_sync[1]};

  logic [7:0] lctrl;
  logic [7:0] lloc [4];
  assign lctrl   = cfg_sync[39:32];
  assign lloc[0] = cfg_sync[7:0];
  assign lloc[1] = cfg_sync[15:8];
  assign lloc[2] = cfg_sync[23:16];
  assign lloc[3] = cfg_sync[31:24];

  logic       pat_mode;
  logic [1:0] fmt;
  assign pat_mode = lctrl[`CTRL_ENABLE_BIT];
  assign fmt      = lctrl[`CTRL_FMT_HI:`CTRL_FMT_LO];

  // --------------------------------------------------------------------------
  // Read-latency pipeline (link clock)
  // --------------------------------------------------------------------------
  // One pipe stage per latency cycle; each slot keeps its own location, so
  // reads every BURST_UI cycles stream back to back with no idle gap. One
  // stage beyond the largest latency lets a long preamble open a cycle early.
  // streaming reads
  read_cmd_t pipe [17];
  read_cmd_t next_pipe [17];

  always_comb begin
    next_pipe[0] = read_cmd;
    for (int i = 1; i < 17; i++) begin
      next_pipe[i] = pipe[i-1];
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      for (int i = 0; i < 17; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 17; i++) begin
        pipe[i] <= next_pipe[i];
      end
    end
  end

  // The data-aligned tap starts a short-preamble burst and chains the next
  // burst on the last UI. A long preamble opens from the tap one stage
  // earlier, so data latency and cadence do not depend on the preamble;
  // otherwise a long preamble would miss every back-to-back read.
  read_cmd_t launch, launch_early;
  assign launch_early = pipe[READ_LATENCY];
  assign launch       = pipe[5'(READ_LATENCY) + 5'h1];

  // --------------------------------------------------------------------------
  // Burst engine
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, PREAMBLE, BURST} burst_state_t;
  burst_state_t state, next_state;
  logic [2:0]   ui, next_ui;
  logic [1:0]   cur_loc, next_cur_loc;
  logic         cur_pat, next_cur_pat;
  logic [15:0]  next_dq;
  logic         next_dq_oe, next_dqs, next_dqs_oe;
  logic         pre_long;

  assign pre_long = lctrl[`CTRL_PRE_BIT];

  // preamble length picks the opening tap
  read_cmd_t opener;
  assign opener = pre_long ? launch_early : launch;

  // Lane data for the current UI, built per lane.
  logic [15:0] lane_bits;
  genvar k;
  generate
    for (k = 0; k < 16; k++) begin : g_lane
      localparam logic [1:0] ROT = 2'(k % 4);
      always_comb begin
        case (fmt)
          `FMT_SERIAL:   lane_bits[k] = lloc[cur_loc][ui];
          `FMT_PARALLEL: lane_bits[k] = lloc[0][k % 8];
          `FMT_STAGGER:  lane_bits[k] = lloc[2'(cur_loc + ROT)][ui];
          // The reserved code drives zeros rather than guess at a format.
          default:       lane_bits[k] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_comb begin
    next_state   = state;
    next_ui      = ui;
    next_cur_loc = cur_loc;
    next_cur_pat = cur_pat;
    next_dq      = 16'h0000;
    next_dq_oe   = 1'b0;
    next_dqs     = 1'b0;
    next_dqs_oe  = 1'b0;
    case (state)
      IDLE: begin
        // bank bits of the read pick the location
        if (opener.valid) begin
          next_cur_loc = opener.loc;
          next_cur_pat = pat_mode & ~opener.array_sel;
          next_dqs_oe  = 1'b1;
          next_state   = pre_long ? PREAMBLE : BURST;
          next_ui      = 3'h0;
        end
      end
      PREAMBLE: begin
        next_dqs_oe = 1'b1;
        next_state  = BURST;
      end
      BURST: begin
        next_dq_oe  = 1'b1;
        next_dqs_oe = 1'b1;
        next_dqs    = ui[0];
        // array data outside pattern mode; never inverted here
        next_dq     = cur_pat ? lane_bits : array_data;
        // Lanes above the device width stay low, so unused pins never toggle.
        if (WIDTH == 4) begin
          next_dq[15:4] = 12'h000;
        end else if (WIDTH == 8) begin
          next_dq[15:8] = 8'h00;
        end
        next_ui = ui + 3'h1;
        // A read whose tap fires before the last UI is dropped: the
        // controller has to space its reads by one whole burst.
        if (ui == 3'(`BURST_UI - 1)) begin
          if (launch.valid) begin
            next_cur_loc = launch.loc;
            next_cur_pat = pat_mode & ~launch.array_sel;
            next_ui      = 3'h0;
          end else begin
            next_state = IDLE;
          end
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state      <= IDLE;
      ui         <= 3'h0;
      cur_loc    <= 2'h0;
      cur_pat    <= 1'b0;
      dq_out     <= '0;
      link_busy  <= 1'b0;
    end else begin
      state      <= next_state;
      ui         <= next_ui;
      cur_loc    <= next_cur_loc;
      cur_pat    <= next_cur_pat;
      dq_out.dq     <= next_dq;
      dq_out.dq_oe  <= next_dq_oe;
      dq_out.dqs    <= next_dqs;
      dq_out.dqs_oe <= next_dqs_oe;
      link_busy  <= (next_state != IDLE);
    end
  end
endmodule

// ===== readout_checker.sv
// Port-level assertions for the pattern readout formatter.
`include "pattern_readout_defs.svh"
module readout_checker
  import pattern_readout_pkg::*;
(
  // System side
  input wire logic                           clk,
  input wire logic                           rst,
  input wire logic [3:0]                     reg_addr,
  input wire logic [7:0]                     reg_wdata,
  input wire logic                           reg_write,
  // Link side
  input wire logic                           link_clk,
  input wire logic                           link_rst,
  input wire pattern_readout_pkg::read_cmd_t read_cmd,
  input wire pattern_readout_pkg::dq_out_t   dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl;
  logic [7:0] loc0;
  // Shadow copies; the bench only reconfigures while the data bus is idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      loc0 <= `LOC_RESET;
    end else if (reg_write && reg_addr == `ADDR_CTRL) begin
      ctrl <= reg_wdata;
    end else if (reg_write && reg_addr == `ADDR_LOC0) begin
      loc0 <= reg_wdata;
    end
  end
  wire logic [1:0] fmt = ctrl[`CTRL_FMT_HI:`CTRL_FMT_LO];
  wire logic       on  = dq_out.dq_oe && ctrl[`CTRL_ENABLE_BIT];
  default clocking @(posedge link_clk); endclocking
  default disable iff (link_rst);
  pre_strobe_a: assert property ($rose(dq_out.dq_oe) |-> $past(dq_out.dqs_oe))
    else $error("data without strobe preamble");
  dqs_toggle_a: assert property (dq_out.dq_oe && $past(dq_out.dq_oe) |-> dq_out.dqs != $past(dq_out.dqs))
    else $error("strobe not toggling");
  burst_len_a: assert property ($rose(dq_out.dq_oe) |-> dq_out.dq_oe[*8])
    else $error("burst shorter than eight");
  read_answer_a: assert property (read_cmd.valid && !dq_out.dqs_oe |-> ##[1:24] dq_out.dqs_oe)
    else $error("read not answered");
  serial_lanes_a: assert property (on && fmt == `FMT_SERIAL |-> dq_out.dq == {16{dq_out.dq[0]}})
    else $error("serial lanes differ");
  par_hold_a: assert property (on && $past(on) && fmt == `FMT_PARALLEL |-> $stable(dq_out.dq))
    else $error("parallel lanes moved");
  par_loc0_a: assert property (on && fmt == `FMT_PARALLEL |-> dq_out.dq == {2{loc0}})
    else $error("parallel data wrong");
  stag_copy_a: assert property (on && fmt == `FMT_STAGGER |->
    dq_out.dq[15:8] == dq_out.dq[7:0] && dq_out.dq[7:4] == dq_out.dq[3:0])
    else $error("staggered copy wrong");
endmodule

// ===== read_issuer.sv
// Controller model that issues READ commands on the link clock.
module read_issuer (
  // Link side
  input  wire logic                      link_clk,
  output pattern_readout_pkg::read_cmd_t read_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  import pattern_readout_pkg::*;
  initial read_cmd = '0;
  // one burst apart
  // Reads are spaced by exactly one burst so the bus streams without idle UIs.
  task send(input logic [1:0] where, input logic arr);
    @(posedge link_clk);
    read_cmd <= '{1'b1, where, arr};
    @(posedge link_clk);
    read_cmd <= '0;
    repeat (6) @(posedge link_clk);
  endtask
endmodule

// ===== pattern_readout_tb.sv
// Self-checking bench for the pattern readout formatter.
`include "pattern_readout_defs.svh"
module pattern_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pattern_readout_pkg::*;
  logic        clk, link_clk;
  logic        rst = 1'b1, link_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [15:0] array_data = 16'h0000;
  logic [15:0] ui [32];
  logic [7:0]  loc [4];
  read_cmd_t   read_cmd;
  dq_out_t     dq_out;
  int          error_cnt = 0;
  int          comparisons = 0;
  pattern_readout #(.WIDTH(16)) pattern_readout_inst (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .link_rst(link_rst), .read_cmd(read_cmd), .array_data(array_data), .dq_out(dq_out));
  read_issuer read_issuer_inst (.link_clk(link_clk), .read_cmd(read_cmd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #2;
    forever #24 link_clk = ~link_clk;
  end
  task chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk("reg", {8'h00, reg_rdata}, {8'h00, e});
  endtask
  // The settings need three link edges to cross before the next read.
  task cfg(input logic [7:0] c);
    wr(`ADDR_CTRL, c);
    repeat (4) @(posedge link_clk);
  endtask
  // Data is taken at the falling link edge, where the outputs have settled.
  task burst(input logic [1:0] first, input int n, input logic arr);
    fork
      for (int r = 0; r < n / 8; r++)
        read_issuer_inst.send(2'(first + r), arr);
      begin
        int w;
        w = 0;
        @(negedge link_clk);
        while (dq_out.dq_oe !== 1'b1 && w < 40) begin
          w++;
          @(negedge link_clk);
        end
        chk("burst start", 16'(w < 40), 16'h0001);
        for (int i = 0; i < n; i++) begin
          ui[i] = dq_out.dq;
          @(negedge link_clk);
        end
      end
    join
  endtask
  task serial_dbi;
    // serial, the format a controller keeps for mode readouts.
    cfg(8'h09);
    burst(2'h0, 8, 1'b0);
    for (int i = 0; i < 8; i++)
      chk("serial", ui[i], {16{loc[0][i]}});
  endtask
  task parallel_loc0;
    // only location 0 is read while the parallel format is set.
    cfg(8'h03);
    burst(2'h0, 8, 1'b0);
    for (int i = 0; i < 8; i++)
      chk("parallel", ui[i], {2{loc[0]}});
  endtask
  task stagger_chain;
    cfg(8'h15);
    burst(2'h1, 32, 1'b0);
    for (int i = 0; i < 32; i++)
      for (int k = 0; k < 16; k++)
        chk("stagger", 16'(ui[i][k]), 16'(loc[(1 + i / 8 + k) % 4][i % 8]));
  endtask
  task array_and_reserved;
    @(posedge link_clk);
    array_data <= 16'hbeef;
    cfg(8'h00);
    burst(2'h2, 8, 1'b0);
    for (int i = 0; i < 8; i++)
      chk("array", ui[i], 16'hbeef);
    // Uniform array data keeps the serial lane assertion valid here.
    @(posedge link_clk);
    array_data <= 16'hffff;
    cfg(8'h01);
    burst(2'h2, 8, 1'b1);
    for (int i = 0; i < 8; i++)
      chk("array select", ui[i], 16'hffff);
    cfg(8'h07);
    burst(2'h0, 8, 1'b0);
    for (int i = 0; i < 8; i++)
      chk("reserved", ui[i], 16'h0000);
  endtask
  task reg_readback;
    rd(`ADDR_LOC3, 8'he1);
    rd(`ADDR_CTRL, 8'h07);
    rd(`ADDR_STATUS, 8'h00);
    rd(4'hf, 8'h00);
  endtask
  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
  initial begin
    loc = '{8'h96, 8'h3c, 8'h0f, 8'he1};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge link_clk);
    link_rst <= 1'b0;
    for (int k = 0; k < 4; k++)
      wr(4'(`ADDR_LOC0 + k), loc[k]);
    serial_dbi;
    parallel_loc0;
    stagger_chain;
    array_and_reserved;
    reg_readback;
    end_sim;
  end
endmodule
bind pattern_readout readout_checker readout_checker_inst (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .link_clk(link_clk),
  .link_rst(link_rst), .read_cmd(read_cmd), .dq_out(dq_out));
